// *** design/rsq_consts.svh ***
`ifndef RSQ_CONSTS_SVH
`define RSQ_CONSTS_SVH
// Register indices, byte address is index times four
`define RSQ_IDX_MODE 10'h000
`define RSQ_IDX_PRELEN 10'h001
`define RSQ_IDX_POSTLEN 10'h002
`define RSQ_IDX_SEGCNT 10'h003
`define RSQ_IDX_MEMSIZE 10'h004
`define RSQ_IDX_MEMDIAG 10'h005
`define RSQ_IDX_BTYPE 10'h008
`define RSQ_IDX_BDIR 10'h009
`define RSQ_IDX_NOTIFY 10'h00A
`define RSQ_IDX_OFFS_LO 10'h00B
`define RSQ_IDX_OFFS_HI 10'h00C
`define RSQ_IDX_LEN_LO 10'h00D
`define RSQ_IDX_LEN_HI 10'h00E
`define RSQ_IDX_BUFCTL 10'h00F
`define RSQ_IDX_XSTAT 10'h010
`define RSQ_IDX_CMD 10'h064
`define RSQ_IDX_STATUS 10'h06E
// Command word bit positions
`define RSQ_CMD_START 2
`define RSQ_CMD_TRIGEN 3
`define RSQ_CMD_FORCE 4
`define RSQ_CMD_TRIGDIS 5
`define RSQ_CMD_HALT 6
`define RSQ_CMD_DMAGO 16
`define RSQ_CMD_DMAHALT 18
// Mode register bits
`define RSQ_MODE_GEN 0
`define RSQ_MODE_MULTI 1
// Buffer control bits
`define RSQ_BUF_DEFINE 0
`define RSQ_BUF_INVAL 1
// Buffer type codes
`define RSQ_BT_DATA 32'h0000_03E8
`define RSQ_BT_SLOW 32'h0000_07D0
`define RSQ_BT_TSTAMP 32'h0000_0BB8
// Direction codes
`define RSQ_DIR_H2B 2'h0
`define RSQ_DIR_B2H 2'h1
`define RSQ_DIR_B2A 2'h2
`define RSQ_DIR_A2B 2'h3
// Bytes moved per transfer beat
`define RSQ_BEAT_BYTES 64'h0000_0000_0000_0004
// Reset values
`define RSQ_RST_PRELEN 32'h0000_0010
`define RSQ_RST_POSTLEN 32'h0000_0010
`define RSQ_RST_SEGCNT 32'h0000_0001
`endif

// *** design/rsq_pkg.sv ***
package rsq_pkg;
    typedef enum logic [4:0] {
        RSQ_IDLE = 5'b00001,
        RSQ_PRE = 5'b00010,
        RSQ_WAIT = 5'b00100,
        RSQ_POST = 5'b01000,
        RSQ_PLAY = 5'b10000
    } rsq_state_e;

    typedef struct packed {
        logic segment_pretrig_flag;
        logic run_finished_flag;
        logic first_trigger_seen_flag;
        logic first_pretrig_filled_flag;
    } rsq_stat_s;

    typedef struct packed {
        logic [31:0] btype;
        logic [1:0] dir;
        logic [31:0] notify_byte_count;
        logic [63:0] board_memory_offset;
        logic [63:0] transfer_length_bytes;
        logic valid;
    } rsq_buf_s;
endpackage : rsq_pkg

// *** design/rsq_run_status.sv ***
// Overview of operation
// R1 - Read-only status word is a bitmap
// R2 - Acquisition sets first-pretrigger bit when filled
// R3 - Multi-segment: first segment only, cleared at end
// R4 - First trigger sets trigger bit
// R5 - Run end sets ready bit
// R6 - Every filled pretrigger area sets segment bit
// R7 - Multi-segment: segment bit cleared at trigger
// R8 - Start acquires pretrigger until one area full
// R9 - Triggers count only while detection enabled
// R10 - Trigger then posttrigger then ready in acquisition
// R11 - Generation start waits armed for trigger
// R12 - Generation trigger replays, then ready and stop
// R13 - Transfer status shares the run status word
// R14 - Host sets memory size before transfer; the code never checks memsize_r when a transfer starts
// R15 - Host sizes hardware buffer before defining buffers; the code has no buffer size register and checks no size at define
// R16 - Transfer needs a defined buffer first
// R17 - Buffer serves one transfer, then invalidated
// R18 - Buffer type codes 1000, 2000, 3000
// R19 - Direction codes 0 to 3
// R20 - Direction must match mode unless diagnostic
// R21 - Pulse each notify count, zero means end
// R22 - Offset and length are 64-bit byte values
// R23 - Start 4h and trigger enable 8h combinable
// R24 - Halt 40h ends run, idle no effect
// R25 - New run clears progress flags
`timescale 1ns/1ps
`include "rsq_consts.svh"
`default_nettype none
module rsq_run_status (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_tick,
    input wire logic trigger_in,
    input wire logic xfer_beat,
    output logic run_busy,
    output logic replay_on,
    output logic xfer_active,
    output logic [1:0] xfer_dir,
    output logic notify_pulse
);
    rsq_pkg::rsq_state_e state_r;
    rsq_pkg::rsq_stat_s stat_r;
    rsq_pkg::rsq_buf_s buf_r;
    logic [1:0] mode_r;
    logic [31:0] prelen_r, postlen_r, segcnt_r, memsize_r;
    logic memdiag_r, trig_en_r, blk_rdy_r, dir_err_r, def_err_r;
    logic [31:0] cnt_r, seg_r, note_r;
    logic [63:0] done_r;
    logic [9:0] idx;
    logic acc, wr, cmd_wr, dma_wr, known;
    logic gen, multi, c_start, c_halt;
    logic fill_done, tick_done, trig_hit, last_seg;
    logic ev_fill, ev_trig, ev_end, dir_ok, go_ok, bt_ok;
    logic beat_end, beat_note;

    assign idx = paddr[11:2];
    assign acc = psel & penable & pready;
    assign wr = acc & pwrite;
    assign gen = mode_r[`RSQ_MODE_GEN];
    assign multi = mode_r[`RSQ_MODE_MULTI];
    // Card commands ignored during memory diagnostics
    assign cmd_wr = wr && idx == `RSQ_IDX_CMD && !memdiag_r;
    // R13 transfer commands share word
    assign dma_wr = wr && idx == `RSQ_IDX_CMD;
    // R23 combined command bits
    assign c_start = cmd_wr & pwdata[`RSQ_CMD_START] & (state_r == rsq_pkg::RSQ_IDLE);
    // R24 halt only while running
    assign c_halt = cmd_wr & pwdata[`RSQ_CMD_HALT] & (state_r != rsq_pkg::RSQ_IDLE);
    assign fill_done = sample_tick && (cnt_r + 32'h0000_0001 >= prelen_r);
    assign tick_done = sample_tick && (cnt_r + 32'h0000_0001 >= postlen_r);
    // R9 trigger gated by enable
    assign trig_hit = trig_en_r &
        (trigger_in | (cmd_wr & pwdata[`RSQ_CMD_FORCE]));
    assign last_seg = !multi || gen || (seg_r + 32'h0000_0001 >= segcnt_r);
    assign ev_fill = !c_halt && state_r == rsq_pkg::RSQ_PRE && fill_done;
    assign ev_trig = !c_halt && state_r == rsq_pkg::RSQ_WAIT && trig_hit;
    assign ev_end = c_halt || ((state_r == rsq_pkg::RSQ_POST ||
        state_r == rsq_pkg::RSQ_PLAY) && tick_done && last_seg);

    always_comb begin
        unique case (idx)
            `RSQ_IDX_MODE, `RSQ_IDX_PRELEN, `RSQ_IDX_POSTLEN,
            `RSQ_IDX_SEGCNT, `RSQ_IDX_MEMSIZE, `RSQ_IDX_MEMDIAG,
            `RSQ_IDX_BTYPE, `RSQ_IDX_BDIR, `RSQ_IDX_NOTIFY,
            `RSQ_IDX_OFFS_LO, `RSQ_IDX_OFFS_HI, `RSQ_IDX_LEN_LO,
            `RSQ_IDX_LEN_HI, `RSQ_IDX_BUFCTL, `RSQ_IDX_XSTAT,
            `RSQ_IDX_CMD, `RSQ_IDX_STATUS: known = 1'b1;
            default: known = 1'b0;
        endcase
    end

    // APB answer one cycle after setup
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & (~known |
                (pwrite & (idx == `RSQ_IDX_STATUS || idx == `RSQ_IDX_XSTAT)) |
                (~pwrite & idx == `RSQ_IDX_CMD));
            if (psel & ~penable & ~pwrite) begin
                unique case (idx)
                    `RSQ_IDX_MODE: prdata <= {30'h0000_0000, mode_r};
                    `RSQ_IDX_PRELEN: prdata <= prelen_r;
                    `RSQ_IDX_POSTLEN: prdata <= postlen_r;
                    `RSQ_IDX_SEGCNT: prdata <= segcnt_r;
                    `RSQ_IDX_MEMSIZE: prdata <= memsize_r;
                    `RSQ_IDX_MEMDIAG: prdata <= {31'h0000_0000, memdiag_r};
                    `RSQ_IDX_BTYPE: prdata <= buf_r.btype;
                    `RSQ_IDX_BDIR: prdata <= {30'h0000_0000, buf_r.dir};
                    `RSQ_IDX_NOTIFY: prdata <= buf_r.notify_byte_count;
                    `RSQ_IDX_OFFS_LO: prdata <= buf_r.board_memory_offset[31:0];
                    `RSQ_IDX_OFFS_HI: prdata <= buf_r.board_memory_offset[63:32];
                    `RSQ_IDX_LEN_LO: prdata <= buf_r.transfer_length_bytes[31:0];
                    `RSQ_IDX_LEN_HI: prdata <= buf_r.transfer_length_bytes[63:32];
                    `RSQ_IDX_XSTAT: prdata <= {28'h0000_000, def_err_r, dir_err_r,
                        xfer_active, buf_r.valid};
                    // R1 bitmap status word
                    // R13 transfer bit in run word
                    `RSQ_IDX_STATUS: prdata <= {23'h00_0000, blk_rdy_r, 4'h0, stat_r};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_r <= 2'h0;
            prelen_r <= `RSQ_RST_PRELEN;
            postlen_r <= `RSQ_RST_POSTLEN;
            segcnt_r <= `RSQ_RST_SEGCNT;
            memsize_r <= 32'h0000_0000;
            memdiag_r <= 1'b0;
        end else if (wr) begin
            unique case (idx)
                `RSQ_IDX_MODE: mode_r <= pwdata[1:0];
                `RSQ_IDX_PRELEN: prelen_r <= pwdata;
                `RSQ_IDX_POSTLEN: postlen_r <= pwdata;
                `RSQ_IDX_SEGCNT: segcnt_r <= pwdata;
                `RSQ_IDX_MEMSIZE: memsize_r <= pwdata;
                `RSQ_IDX_MEMDIAG: memdiag_r <= pwdata[0];
                default: ;
            endcase
        end
    end

    // R9 trigger enable state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trig_en_r <= 1'b0;
        end else if (cmd_wr) begin
            if (pwdata[`RSQ_CMD_TRIGEN]) begin
                trig_en_r <= 1'b1;
            end else if (pwdata[`RSQ_CMD_TRIGDIS] || c_start) begin
                trig_en_r <= 1'b0;
            end
        end
    end

    // Run sequencer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= rsq_pkg::RSQ_IDLE;
            cnt_r <= 32'h0000_0000;
            seg_r <= 32'h0000_0000;
        end else if (c_halt) begin
            state_r <= rsq_pkg::RSQ_IDLE;
        end else begin
            unique case (state_r)
                rsq_pkg::RSQ_IDLE: begin
                    if (c_start) begin
                        cnt_r <= 32'h0000_0000;
                        seg_r <= 32'h0000_0000;
                        // R11 generation arms, R8 acquisition fills
                        state_r <= gen ? rsq_pkg::RSQ_WAIT : rsq_pkg::RSQ_PRE;
                    end
                end
                rsq_pkg::RSQ_PRE: begin
                    if (fill_done) begin
                        cnt_r <= 32'h0000_0000;
                        state_r <= rsq_pkg::RSQ_WAIT;
                    end else if (sample_tick) begin
                        cnt_r <= cnt_r + 32'h0000_0001;
                    end
                end
                rsq_pkg::RSQ_WAIT: begin
                    if (trig_hit) begin
                        cnt_r <= 32'h0000_0000;
                        // R10 posttrigger, R12 replay
                        state_r <= gen ? rsq_pkg::RSQ_PLAY : rsq_pkg::RSQ_POST;
                    end
                end
                rsq_pkg::RSQ_POST, rsq_pkg::RSQ_PLAY: begin
                    if (tick_done) begin
                        cnt_r <= 32'h0000_0000;
                        if (last_seg) begin
                            state_r <= rsq_pkg::RSQ_IDLE;
                        end else begin
                            seg_r <= seg_r + 32'h0000_0001;
                            state_r <= rsq_pkg::RSQ_PRE;
                        end
                    end else if (sample_tick) begin
                        cnt_r <= cnt_r + 32'h0000_0001;
                    end
                end
                default: state_r <= rsq_pkg::RSQ_IDLE;
            endcase
        end
    end

    // Status flags
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stat_r <= '0;
        end else if (c_start) begin
            // R25 fresh flags per run
            stat_r <= '0;
        end else begin
            // R2 R3 first segment only
            if (ev_fill && seg_r == 32'h0000_0000) begin
                stat_r.first_pretrig_filled_flag <= 1'b1;
            end else if (ev_end && multi) begin
                // R3 cleared at acquisition end
                stat_r.first_pretrig_filled_flag <= 1'b0;
            end
            // R4 first trigger seen
            if (ev_trig) begin
                stat_r.first_trigger_seen_flag <= 1'b1;
            end
            // R5 run finished
            if (ev_end) begin
                stat_r.run_finished_flag <= 1'b1;
            end
            // R6 each area, R7 cleared by trigger
            if (ev_fill) begin
                stat_r.segment_pretrig_flag <= 1'b1;
            end else if (ev_trig && multi) begin
                stat_r.segment_pretrig_flag <= 1'b0;
            end
        end
    end

    // R20 direction against mode
    assign dir_ok = memdiag_r || (gen ?
        (buf_r.dir == `RSQ_DIR_H2B || buf_r.dir == `RSQ_DIR_A2B) :
        (buf_r.dir == `RSQ_DIR_B2H || buf_r.dir == `RSQ_DIR_B2A));
    // R16 defined buffer needed
    assign go_ok = buf_r.valid && !xfer_active && dir_ok;
    // R18 known type codes
    assign bt_ok = buf_r.btype == `RSQ_BT_DATA || buf_r.btype == `RSQ_BT_SLOW ||
        buf_r.btype == `RSQ_BT_TSTAMP;
    assign beat_end = xfer_active && xfer_beat &&
        (done_r + `RSQ_BEAT_BYTES >= buf_r.transfer_length_bytes);
    assign beat_note = xfer_active && xfer_beat &&
        buf_r.notify_byte_count != 32'h0000_0000 &&
        (note_r + 32'h0000_0004 >= buf_r.notify_byte_count);

    // Buffer definition
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            buf_r <= '0;
            def_err_r <= 1'b0;
        end else begin
            if (wr && !xfer_active) begin
                unique case (idx)
                    `RSQ_IDX_BTYPE: buf_r.btype <= pwdata;
                    // R19 two-bit direction code
                    `RSQ_IDX_BDIR: buf_r.dir <= pwdata[1:0];
                    `RSQ_IDX_NOTIFY: buf_r.notify_byte_count <= pwdata;
                    // R22 64-bit byte values
                    `RSQ_IDX_OFFS_LO: buf_r.board_memory_offset[31:0] <= pwdata;
                    `RSQ_IDX_OFFS_HI: buf_r.board_memory_offset[63:32] <= pwdata;
                    `RSQ_IDX_LEN_LO: buf_r.transfer_length_bytes[31:0] <= pwdata;
                    `RSQ_IDX_LEN_HI: buf_r.transfer_length_bytes[63:32] <= pwdata;
                    default: ;
                endcase
            end
            // R17 invalidated at end or on request
            if (beat_end || (dma_wr && pwdata[`RSQ_CMD_DMAHALT]) ||
                (wr && idx == `RSQ_IDX_BUFCTL && pwdata[`RSQ_BUF_INVAL])) begin
                buf_r.valid <= 1'b0;
            end else if (wr && idx == `RSQ_IDX_BUFCTL &&
                pwdata[`RSQ_BUF_DEFINE] && !xfer_active) begin
                buf_r.valid <= bt_ok;
                def_err_r <= !bt_ok;
            end
        end
    end

    // Transfer progress and notify
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            xfer_active <= 1'b0;
            xfer_dir <= 2'h0;
            done_r <= 64'h0000_0000_0000_0000;
            note_r <= 32'h0000_0000;
            notify_pulse <= 1'b0;
            dir_err_r <= 1'b0;
            blk_rdy_r <= 1'b0;
        end else begin
            notify_pulse <= beat_end || beat_note;
            if (beat_end || beat_note) begin
                blk_rdy_r <= 1'b1;
            end else if (dma_wr && pwdata[`RSQ_CMD_DMAGO]) begin
                blk_rdy_r <= 1'b0;
            end
            if (dma_wr && pwdata[`RSQ_CMD_DMAHALT]) begin
                xfer_active <= 1'b0;
            end else if (dma_wr && pwdata[`RSQ_CMD_DMAGO]) begin
                xfer_active <= go_ok;
                dir_err_r <= !dir_ok;
                xfer_dir <= buf_r.dir;
                done_r <= 64'h0000_0000_0000_0000;
                note_r <= 32'h0000_0000;
            end else if (xfer_active && xfer_beat) begin
                // R21 notify count or end only
                done_r <= done_r + `RSQ_BEAT_BYTES;
                note_r <= beat_note ? 32'h0000_0000 : note_r + 32'h0000_0004;
                if (beat_end) begin
                    xfer_active <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            run_busy <= 1'b0;
            replay_on <= 1'b0;
        end else begin
            run_busy <= !ev_end && (c_start || (state_r != rsq_pkg::RSQ_IDLE));
            replay_on <= !ev_end && (ev_trig ? gen : state_r == rsq_pkg::RSQ_PLAY);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_start;
        c_start;
    endsequence
    sequence s_trig;
        ev_trig;
    endsequence

    a_start_clears: assert property (s_start |=> stat_r == '0) // R25
        else $error("start did not clear flags");
    a_gen_armed: assert property (s_start ##0 gen |=> state_r == rsq_pkg::RSQ_WAIT) // R11
        else $error("generation start not armed");
    a_fill_first: assert property (ev_fill && seg_r == 32'h0000_0000 |=>
        stat_r.first_pretrig_filled_flag && stat_r.segment_pretrig_flag) // R2
        else $error("pretrigger fill not flagged");
    a_trig_moves: assert property (s_trig |=> stat_r.first_trigger_seen_flag &&
        (state_r == rsq_pkg::RSQ_POST || state_r == rsq_pkg::RSQ_PLAY)) // R4
        else $error("trigger not taken");
    a_disabled_hold: assert property (state_r == rsq_pkg::RSQ_WAIT && !trig_en_r &&
        !c_halt |=> state_r == rsq_pkg::RSQ_WAIT) // R9
        else $error("trigger taken while disabled");
    a_end_ready: assert property (ev_end |=> stat_r.run_finished_flag &&
        state_r == rsq_pkg::RSQ_IDLE ##1 !run_busy) // R5
        else $error("end of run not reported");
    a_seg_cleared: assert property (s_trig ##0 multi && !gen |=>
        !stat_r.segment_pretrig_flag) // R7
        else $error("segment flag not cleared");
    a_idle_halt: assert property (cmd_wr && pwdata[`RSQ_CMD_HALT] &&
        state_r == rsq_pkg::RSQ_IDLE && !c_start |=> $stable(stat_r)) // R24
        else $error("halt changed idle card");
    a_buf_once: assert property (beat_end |=> !buf_r.valid && !xfer_active
        ##0 notify_pulse) // R17
        else $error("buffer not released");
    a_dir_refuse: assert property (dma_wr && pwdata[`RSQ_CMD_DMAGO] && !dir_ok &&
        !pwdata[`RSQ_CMD_DMAHALT] |=> !xfer_active && dir_err_r) // R20
        else $error("wrong direction accepted");
endmodule : rsq_run_status
`default_nettype wire

// *** testbench/rsq_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rsq_host_model (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end

    // One APB transfer, held until pready is sampled high
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data shows a changed pattern, not the old value
        pwdata <= ~d;
    endtask : xfer
endmodule : rsq_host_model
`default_nettype wire

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
`include "rsq_consts.svh"
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic sample_tick, trigger_in, xfer_beat;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic run_busy, replay_on, xfer_active, notify_pulse;
    logic [1:0] xfer_dir;
    int err_total = 0;
    int n_checks = 0;

    rsq_host_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    rsq_run_status uut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_tick(sample_tick), .trigger_in(trigger_in),
        .xfer_beat(xfer_beat), .run_busy(run_busy), .replay_on(replay_on),
        .xfer_active(xfer_active), .xfer_dir(xfer_dir), .notify_pulse(notify_pulse));

    always #25 clk = ~clk;

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic rd(input logic [9:0] idx, output logic [31:0] q, output logic e);
        host.xfer(1'b0, {idx, 2'b00}, 32'h0000_0000, q, e);
    endtask : rd

    task automatic wr(input logic [9:0] idx, input logic [31:0] d, output logic e);
        logic [31:0] q;
        host.xfer(1'b1, {idx, 2'b00}, d, q, e);
    endtask : wr

    task automatic w(input logic [9:0] idx, input logic [31:0] d);
        logic e;
        wr(idx, d, e);
    endtask : w

    task automatic st(input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        rd(`RSQ_IDX_STATUS, q, e);
        check("status", q, exp);
    endtask : st

    // k: 0 sample tick, 1 trigger, 2 transfer beat
    task automatic pulse(input int k);
        @(posedge clk);
        case (k)
            0: sample_tick <= 1'b1;
            1: trigger_in <= 1'b1;
            default: xfer_beat <= 1'b1;
        endcase
        @(posedge clk);
        {sample_tick, trigger_in, xfer_beat} <= 3'b000;
        #1;
    endtask : pulse

    task automatic t_regs();
        logic [31:0] q;
        logic e;
        st(32'h0000_0000);
        wr(`RSQ_IDX_STATUS, 32'h0000_000F, e);
        check("status write err", 32'(e), 32'h0000_0001);
        st(32'h0000_0000);
        rd(10'h3FF, q, e);
        check("unmapped err", 32'(e), 32'h0000_0001);
    endtask : t_regs

    task automatic t_acq();
        w(`RSQ_IDX_PRELEN, 32'h0000_0002);
        w(`RSQ_IDX_POSTLEN, 32'h0000_0001);
        w(`RSQ_IDX_CMD, 32'h0000_000C);
        pulse(0);
        st(32'h0000_0000);
        pulse(0);
        st(32'h0000_0009);
        pulse(1);
        st(32'h0000_000B);
        pulse(0);
        st(32'h0000_000F);
        check("busy end", 32'(run_busy), 32'h0000_0000);
    endtask : t_acq

    task automatic t_gate();
        w(`RSQ_IDX_CMD, 32'h0000_0004);
        pulse(0);
        pulse(0);
        st(32'h0000_0009);
        pulse(1);
        st(32'h0000_0009);
        w(`RSQ_IDX_CMD, 32'h0000_0008);
        w(`RSQ_IDX_CMD, 32'h0000_0020);
        pulse(1);
        st(32'h0000_0009);
        w(`RSQ_IDX_CMD, 32'h0000_0008);
        w(`RSQ_IDX_CMD, 32'h0000_0010);
        st(32'h0000_000B);
        w(`RSQ_IDX_CMD, 32'h0000_0040);
        st(32'h0000_000F);
        w(`RSQ_IDX_CMD, 32'h0000_0040);
        st(32'h0000_000F);
        check("busy halt", 32'(run_busy), 32'h0000_0000);
    endtask : t_gate

    task automatic t_multi();
        w(`RSQ_IDX_MODE, 32'h0000_0002);
        w(`RSQ_IDX_SEGCNT, 32'h0000_0002);
        w(`RSQ_IDX_PRELEN, 32'h0000_0001);
        w(`RSQ_IDX_CMD, 32'h0000_000C);
        pulse(0);
        st(32'h0000_0009);
        pulse(1);
        st(32'h0000_0003);
        pulse(0);
        pulse(0);
        st(32'h0000_000B);
        pulse(1);
        pulse(0);
        st(32'h0000_0006);
    endtask : t_multi

    task automatic t_gen();
        w(`RSQ_IDX_MODE, 32'h0000_0001);
        w(`RSQ_IDX_POSTLEN, 32'h0000_0002);
        w(`RSQ_IDX_CMD, 32'h0000_0004);
        pulse(1);
        check("armed busy", 32'(run_busy), 32'h0000_0001);
        check("armed replay", 32'(replay_on), 32'h0000_0000);
        w(`RSQ_IDX_CMD, 32'h0000_0008);
        pulse(1);
        check("replay", 32'(replay_on), 32'h0000_0001);
        st(32'h0000_0002);
        pulse(0);
        pulse(0);
        check("replay end", 32'(replay_on), 32'h0000_0000);
        st(32'h0000_0006);
    endtask : t_gen

    task automatic t_xfer();
        logic [31:0] q;
        logic e;
        w(`RSQ_IDX_MODE, 32'h0000_0000);
        w(`RSQ_IDX_MEMSIZE, 32'h0000_0100);
        w(`RSQ_IDX_BTYPE, `RSQ_BT_DATA);
        w(`RSQ_IDX_BDIR, 32'h0000_0001);
        w(`RSQ_IDX_NOTIFY, 32'h0000_0004);
        w(`RSQ_IDX_LEN_LO, 32'h0000_0008);
        w(`RSQ_IDX_BUFCTL, 32'h0000_0001);
        w(`RSQ_IDX_CMD, 32'h0001_0000);
        @(posedge clk);
        #1;
        check("active", 32'(xfer_active), 32'h0000_0001);
        pulse(2);
        check("notify", 32'(notify_pulse), 32'h0000_0001);
        pulse(2);
        check("end notify", 32'(notify_pulse), 32'h0000_0001);
        check("active end", 32'(xfer_active), 32'h0000_0000);
        st(32'h0000_0106);
        w(`RSQ_IDX_CMD, 32'h0001_0000);
        @(posedge clk);
        #1;
        check("reuse", 32'(xfer_active), 32'h0000_0000);
        for (int t = 0; t < 4; t++) begin
            w(`RSQ_IDX_BTYPE, t == 3 ? 32'h0000_0005 : `RSQ_BT_DATA + 32'(t) * `RSQ_BT_DATA);
            w(`RSQ_IDX_BUFCTL, 32'h0000_0001);
            rd(`RSQ_IDX_XSTAT, q, e);
            check("type valid", q & 32'h0000_0009, t == 3 ? 32'h0000_0008 : 32'h0000_0001);
            w(`RSQ_IDX_BUFCTL, 32'h0000_0002);
            rd(`RSQ_IDX_XSTAT, q, e);
            check("invalidated", q & 32'h0000_0001, 32'h0000_0000);
        end
        for (int d = 0; d < 4; d++) begin
            w(`RSQ_IDX_BTYPE, `RSQ_BT_DATA);
            w(`RSQ_IDX_BDIR, 32'(d));
            w(`RSQ_IDX_BUFCTL, 32'h0000_0001);
            w(`RSQ_IDX_CMD, 32'h0001_0000);
            @(posedge clk);
            #1;
            check("dir ok", 32'(xfer_active), 32'(d == 1 || d == 2));
            if (d == 1 || d == 2)
                check("dir out", 32'(xfer_dir), 32'(d));
            w(`RSQ_IDX_CMD, 32'h0004_0000);
        end
        w(`RSQ_IDX_MEMDIAG, 32'h0000_0001);
        w(`RSQ_IDX_NOTIFY, 32'h0000_0000);
        w(`RSQ_IDX_BDIR, 32'h0000_0000);
        w(`RSQ_IDX_BUFCTL, 32'h0000_0001);
        w(`RSQ_IDX_CMD, 32'h0001_0004);
        @(posedge clk);
        #1;
        check("diag dir", 32'(xfer_active), 32'h0000_0001);
        check("diag start", 32'(run_busy), 32'h0000_0000);
        pulse(2);
        check("no notify", 32'(notify_pulse), 32'h0000_0000);
        pulse(2);
        check("zero notify end", 32'(notify_pulse), 32'h0000_0001);
        w(`RSQ_IDX_MEMDIAG, 32'h0000_0000);
    endtask : t_xfer

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    initial begin
        #(50 * 6000);
        err_total++;
        final_report();
    end

    initial begin
        sample_tick = 1'b0;
        trigger_in = 1'b0;
        xfer_beat = 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_acq();
        t_gate();
        t_multi();
        t_gen();
        t_xfer();
        final_report();
    end
endmodule : testbench
`default_nettype wire
